// file: core/adctc_ctrl.sv
// Purpose: Trigger, reference, range and channel control of a converter.
// Assumes: Trigger sources and converter core share clk; done is a pulse.
// Notes: Window compare uses result bits 9:2 against the 8-bit limits.
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
module adctc_ctrl
  import adctc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_ch1_irq,
  input wire logic event_link_unit,
  input wire logic interval_timer_irq,
  input wire logic conv_done,
  input wire logic [9:0] conversion_result,
  output logic conv_start,
  output logic one_shot,
  output logic [1:0] plus_ref_select,
  output logic minus_ref_select,
  output logic snooze_enable,
  output logic resolution_select,
  output logic [5:0] channel_code,
  output logic conversion_end_irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] trig_cfg, next_trig_cfg; // Trigger config
  logic [7:0] ref_cfg, next_ref_cfg; // Reference and range config
  logic [7:0] upper, next_upper; // Upper limit
  logic [7:0] lower, next_lower; // Lower limit
  logic [7:0] chan, next_chan; // Channel select
  logic flag, next_flag; // Conversion-end flag
  logic mask, next_mask; // Conversion-end mask
  logic enable, next_enable; // Converter enable
  logic sw_start, next_sw_start; // Software start pulse
  logic [9:0] result, next_result; // Last result
  adctc_state_t state, next_state; // Sequencer state
  logic start, next_start; // Start pulse to core
  logic irq, next_irq; // Interrupt line
  logic ack, next_ack; // Bus acknowledge
  logic [31:0] rdat, next_rdat; // Read data
  logic wr_hit, rd_hit; // Bus write and read at ack edge
  logic hw_trig; // Selected hardware trigger
  logic launch; // Start a conversion now
  logic [7:0] cmp_val; // Result scaled to limit width
  logic in_window; // Result within limits
  logic range_hit; // Compare passes for interrupt
  logic chan_ok; // Written channel code is legal
  logic [1:0] tmd, trs; // Trigger mode and source

  // ----------------------------------------------------------------
  // Bus handshake and access decode
  // ----------------------------------------------------------------
  // Access takes effect at the edge where ack is seen high
  assign wr_hit = wb_cyc_i & wb_stb_i & ack & wb_we_i & wb_sel_i[0];
  assign rd_hit = wb_cyc_i & wb_stb_i & ack & ~wb_we_i;
  assign tmd = {trig_cfg[B_TMD_HI], trig_cfg[B_TMD_LO]};
  assign trs = {trig_cfg[B_TRS_HI], trig_cfg[B_TRS_LO]};
  // Ack one cycle after request, read data captured with it
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_rdat = rdat;
    if (wb_cyc_i & wb_stb_i & ~ack) begin
      next_rdat = 32'h0000_0000;
      case (wb_adr_i)
        OFS_TRIG: next_rdat[7:0] = trig_cfg;
        OFS_REF: next_rdat[7:0] = ref_cfg;
        OFS_UPPER: next_rdat[7:0] = upper;
        OFS_LOWER: next_rdat[7:0] = lower;
        OFS_CHAN: next_rdat[7:0] = chan;
        OFS_FLAG: next_rdat[B_FLAG] = flag;
        OFS_MASK: next_rdat[B_FLAG] = mask;
        OFS_CTRL: next_rdat[B_EN] = enable;
        OFS_STAT: begin
          next_rdat[9:0] = result;
          next_rdat[B_BUSY] = (state == ST_BUSY);
        end
        // Unmapped: reads zero, writes ignored
        default: next_rdat = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Channel code legality for the written value
  always_comb begin
    if (wb_dat_i[B_ISS]) begin
      chan_ok = (wb_dat_i[4:0] == CH_TEMP) ||
                (wb_dat_i[4:0] == CH_IREF);
    end else begin
      chan_ok = (wb_dat_i[4:0] <= CH_LOW_MAX) ||
                ((wb_dat_i[4:0] >= CH_HIGH_MIN) &&
                 (wb_dat_i[4:0] <= CH_AMP));
    end
  end
  // Register writes; prohibited codes leave the register unchanged
  always_comb begin
    next_trig_cfg = trig_cfg;
    next_ref_cfg = ref_cfg;
    next_upper = upper;
    next_lower = lower;
    next_chan = chan;
    next_mask = mask;
    next_enable = enable;
    next_sw_start = 1'b0;
    if (wr_hit) begin
      case (wb_adr_i)
        OFS_TRIG: begin
          if (({wb_dat_i[B_TRS_HI], wb_dat_i[B_TRS_LO]} != TRS_BAD) &&
              ({wb_dat_i[B_TMD_HI], wb_dat_i[B_TMD_LO]} != TMD_BAD)) begin
            next_trig_cfg = wb_dat_i[7:0] & TRIG_WMASK;
          end
        end
        OFS_REF: begin
          if (wb_dat_i[7:6] != REFP_BAD) begin
            next_ref_cfg = wb_dat_i[7:0] & REF_WMASK;
          end
        end
        OFS_UPPER: next_upper = wb_dat_i[7:0];
        OFS_LOWER: next_lower = wb_dat_i[7:0];
        OFS_CHAN: begin
          if (chan_ok) begin
            next_chan = wb_dat_i[7:0] & CHAN_WMASK;
          end
        end
        OFS_MASK: next_mask = wb_dat_i[B_FLAG];
        OFS_CTRL: begin
          next_enable = wb_dat_i[B_EN];
          next_sw_start = wb_dat_i[B_START] & wb_dat_i[B_EN];
        end
        default: next_enable = enable;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection and conversion sequencer
  // ----------------------------------------------------------------
  // Hardware source chosen by the source field
  always_comb begin
    case (trs)
      TRS_TIMER: hw_trig = timer_ch1_irq;
      TRS_EVENT: hw_trig = event_link_unit;
      TRS_INTERVAL: hw_trig = interval_timer_irq;
      default: hw_trig = 1'b0;
    endcase
  end
  // Software mode uses the start bit, hardware modes the source
  assign launch = enable & ((tmd == TMD_SW) ? sw_start :
                  (((tmd == TMD_NOWAIT) || (tmd == TMD_WAIT)) & hw_trig));
  // Idle until launched; repeat or stop at each conversion end
  always_comb begin
    next_state = state;
    next_start = 1'b0;
    next_result = result;
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_BUSY;
          next_start = 1'b1;
        end
      end
      ST_BUSY: begin
        if (conv_done) begin
          next_result = conversion_result;
          if (trig_cfg[B_SCM] || !enable) begin
            next_state = ST_IDLE;
          end else begin
            next_start = 1'b1;
          end
        end else if (!enable) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Window compare and interrupt
  // ----------------------------------------------------------------
  assign cmp_val = conversion_result[9:2];
  assign in_window = (lower <= cmp_val) && (cmp_val <= upper);
  assign range_hit = ref_cfg[B_RCK] ? ~in_window : in_window;
  // Flag set by a passing conversion end; set wins over any clear
  always_comb begin
    next_flag = flag;
    if (rd_hit && (wb_adr_i == OFS_FLAG)) begin
      next_flag = 1'b0;
    end
    if (wr_hit && (wb_adr_i == OFS_FLAG) && !wb_dat_i[B_FLAG]) begin
      next_flag = 1'b0;
    end
    if ((state == ST_BUSY) && conv_done && range_hit) begin
      next_flag = 1'b1;
    end
    next_irq = next_flag & ~next_mask;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_cfg <= RST_TRIG;
      ref_cfg <= RST_REF;
      upper <= RST_UPPER;
      lower <= RST_LOWER;
      chan <= RST_CHAN;
      flag <= 1'b0;
      mask <= RST_MASK[B_FLAG];
      enable <= 1'b0;
      sw_start <= 1'b0;
      result <= 10'h000;
      state <= ST_IDLE;
      start <= 1'b0;
      irq <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      trig_cfg <= next_trig_cfg;
      ref_cfg <= next_ref_cfg;
      upper <= next_upper;
      lower <= next_lower;
      chan <= next_chan;
      flag <= next_flag;
      mask <= next_mask;
      enable <= next_enable;
      sw_start <= next_sw_start;
      result <= next_result;
      state <= next_state;
      start <= next_start;
      irq <= next_irq;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign conv_start = start;
  assign one_shot = trig_cfg[B_SCM];
  assign plus_ref_select = {ref_cfg[B_REFP_HI], ref_cfg[B_REFP_LO]};
  assign minus_ref_select = ref_cfg[B_REFM];
  assign snooze_enable = ref_cfg[B_SNZ];
  assign resolution_select = ref_cfg[B_TYP];
  assign channel_code = {chan[B_ISS], chan[4:0]};
  assign conversion_end_irq = irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_inside_sets;
    @(posedge clk) disable iff (!rst_b)
    (state == ST_BUSY && conv_done && !ref_cfg[B_RCK] &&
     lower <= conversion_result[9:2] && conversion_result[9:2] <= upper)
    |=> flag;
  endproperty
  a_inside_sets: assert property (p_inside_sets)
    else $error("inside result did not set flag");
  property p_outside_sets;
    @(posedge clk) disable iff (!rst_b)
    (state == ST_BUSY && conv_done && ref_cfg[B_RCK] &&
     (conversion_result[9:2] < lower || upper < conversion_result[9:2]))
    |=> flag;
  endproperty
  a_outside_sets: assert property (p_outside_sets)
    else $error("outside result did not set flag");
  property p_no_false_flag;
    @(posedge clk) disable iff (!rst_b)
    (!flag && !(state == ST_BUSY && conv_done && range_hit)) |=> !flag;
  endproperty
  a_no_false_flag: assert property (p_no_false_flag)
    else $error("flag rose without passing conversion end");
  property p_irq_mask;
    @(posedge clk) disable iff (!rst_b)
    ##1 (conversion_end_irq == (flag & ~mask));
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt disagrees with flag and mask");
  property p_hw_launch;
    @(posedge clk) disable iff (!rst_b)
    (state == ST_IDLE && enable && tmd == TMD_NOWAIT &&
     trs == TRS_INTERVAL && interval_timer_irq) |=> conv_start;
  endproperty
  a_hw_launch: assert property (p_hw_launch)
    else $error("interval trigger did not start conversion");
  property p_sw_no_hw;
    @(posedge clk) disable iff (!rst_b)
    (state == ST_IDLE && tmd == TMD_SW && !sw_start) |=> !conv_start;
  endproperty
  a_sw_no_hw: assert property (p_sw_no_hw)
    else $error("start without software trigger");
  property p_one_shot_stops;
    @(posedge clk) disable iff (!rst_b)
    (state == ST_BUSY && conv_done && trig_cfg[B_SCM])
    |=> (state == ST_IDLE) && !conv_start;
  endproperty
  a_one_shot_stops: assert property (p_one_shot_stops)
    else $error("single mode did not stop");
  property p_repeat;
    @(posedge clk) disable iff (!rst_b)
    (state == ST_BUSY && conv_done && !trig_cfg[B_SCM] && enable)
    |=> conv_start ##1 !conv_start;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("sequential mode did not restart");
  property p_legal_codes;
    @(posedge clk) disable iff (!rst_b)
    (trs != TRS_BAD) && (plus_ref_select != REFP_BAD);
  endproperty
  a_legal_codes: assert property (p_legal_codes)
    else $error("prohibited code held");
  property p_ack_pulse;
    @(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held two cycles");
  c_outside: cover property (@(posedge clk) disable iff (!rst_b)
    ref_cfg[B_RCK] && conv_done && range_hit);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b)
    conversion_end_irq);
  c_repeat: cover property (@(posedge clk) disable iff (!rst_b)
    state == ST_BUSY && conv_done && conv_start);
endmodule

// file: core/adctc_pkg.sv
// Purpose: Constants for the converter control block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses, one clock.
// Notes: Each register except status sits in the low byte of an aligned word.
// Function
// - Trigger source: timer, event link, interval timer
// - Plus reference: supply, pin, internal; 11 barred
// - Bit 5 selects ground or minus pin
// - Range check clear: irq inside limits inclusive
// - Range check set: irq strictly outside limits
// - Bit 2 enables snooze conversion function
// - Bit 0: 10-bit when clear, 8-bit set
// - Separate 8-bit upper and lower limit registers
// - Channel select: inputs, amplifier, sensor, reference
// - Conversion-end flag pending; software may clear
// - Mask bit 1 blocks, 0 allows servicing
// - Trigger mode: software, hardware no-wait, wait
// - Mode bit: repeat when clear, single when set
package adctc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_TRIG = 6'h00; // Trigger config
  localparam logic [5:0] OFS_REF = 6'h04; // Reference and range config
  localparam logic [5:0] OFS_UPPER = 6'h08; // Upper limit
  localparam logic [5:0] OFS_LOWER = 6'h0c; // Lower limit
  localparam logic [5:0] OFS_CHAN = 6'h10; // Channel select
  localparam logic [5:0] OFS_FLAG = 6'h14; // Interrupt flag
  localparam logic [5:0] OFS_MASK = 6'h18; // Interrupt mask
  localparam logic [5:0] OFS_CTRL = 6'h1c; // Enable and start
  localparam logic [5:0] OFS_STAT = 6'h20; // Result and busy
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [7:0] RST_UPPER = 8'hff;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [7:0] RST_CHAN = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h01;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_TMD_HI = 7; // Trigger mode high
  localparam int B_TMD_LO = 6; // Trigger mode low
  localparam int B_SCM = 5; // Conversion mode
  localparam int B_TRS_HI = 1; // Hardware source high
  localparam int B_TRS_LO = 0; // Hardware source low
  localparam int B_REFP_HI = 7; // Plus reference high
  localparam int B_REFP_LO = 6; // Plus reference low
  localparam int B_REFM = 5; // Minus reference
  localparam int B_RCK = 3; // Range check select
  localparam int B_SNZ = 2; // Snooze enable
  localparam int B_TYP = 0; // Resolution select
  localparam int B_ISS = 7; // Internal source select
  localparam int B_FLAG = 0; // Conversion-end flag and mask
  localparam int B_EN = 0; // Control: converter enable
  localparam int B_START = 1; // Control: software start
  localparam int B_BUSY = 16; // Status: busy
  localparam logic [7:0] TRIG_WMASK = 8'he3; // Writable trigger bits
  localparam logic [7:0] REF_WMASK = 8'hed; // Writable reference bits
  localparam logic [7:0] CHAN_WMASK = 8'h9f; // Writable channel bits
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TMD_SW = 2'h0; // Software trigger
  localparam logic [1:0] TMD_NOWAIT = 2'h2; // Hardware, no wait
  localparam logic [1:0] TMD_WAIT = 2'h3; // Hardware, wait
  localparam logic [1:0] TMD_BAD = 2'h1; // Prohibited mode
  localparam logic [1:0] TRS_TIMER = 2'h0;
  localparam logic [1:0] TRS_EVENT = 2'h1;
  localparam logic [1:0] TRS_BAD = 2'h2;
  localparam logic [1:0] TRS_INTERVAL = 2'h3;
  localparam logic [1:0] REFP_BAD = 2'h3;
  localparam logic [4:0] CH_LOW_MAX = 5'h03; // Inputs 0..3
  localparam logic [4:0] CH_HIGH_MIN = 5'h10; // Inputs 16..22
  localparam logic [4:0] CH_AMP = 5'h17; // Amplifier output
  localparam logic [4:0] CH_TEMP = 5'h00; // Temperature sensor
  localparam logic [4:0] CH_IREF = 5'h01; // Internal reference
  // Conversion sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } adctc_state_t;
endpackage

// file: bench/test_adc_trigger_range_channel_ctrl.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Bus answers are bounded; converter core is played by the bench.
// Notes: Read results go through a queue checked by a separate monitor.
module test_adc_trigger_range_channel_ctrl
  import adctc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conv_done;
  logic [5:0] wb_adr_i, channel_code;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_exp;
  logic [2:0] trg; // Hardware trigger sources: timer, event, interval
  logic [9:0] conversion_result;
  logic conv_start, one_shot, minus_ref_select, snooze_enable;
  logic resolution_select, conversion_end_irq;
  logic [1:0] plus_ref_select;
  logic [31:0] seed = 32'h1bbf863a; // Random state
  logic [31:0] rd_q[$]; // Expected read data, oldest first
  int miscompares = 0;
  int tests_run = 0;

  adctc_ctrl i_adctc_ctrl (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_ch1_irq(trg[0]), .event_link_unit(trg[1]),
    .interval_timer_irq(trg[2]), .conv_done(conv_done),
    .conversion_result(conversion_result), .conv_start(conv_start),
    .one_shot(one_shot), .plus_ref_select(plus_ref_select),
    .minus_ref_select(minus_ref_select), .snooze_enable(snooze_enable),
    .resolution_select(resolution_select), .channel_code(channel_code),
    .conversion_end_irq(conversion_end_irq));

  // Clock of 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One classic cycle; on a read d is the expected data
  task automatic bus(input int w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= (w != 0);
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= w ? d : 32'h0;
    if (!w) rd_q.push_back(d);
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      chk(32'h0, 32'h1, "bus answer timeout");
      final_report();
    end
  endtask

  // Checks for a start pulse within a bounded number of edges
  task automatic wait_start(input int lim, input logic want, input string m);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < lim && !seen; n++) begin
      @(posedge clk);
      if (conv_start === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, want}, m);
  endtask

  // Converter core finishing one conversion
  task automatic finish_conv(input logic [9:0] r);
    @(posedge clk);
    conv_done <= 1'b1;
    conversion_result <= r;
    @(posedge clk);
    conv_done <= 1'b0;
    conversion_result <= ~r;
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    trg[k] <= 1'b1;
    @(posedge clk);
    trg <= 3'h0;
  endtask

  // Monitor: each read answer is matched with the oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) begin
        chk(32'h0, 32'h1, "read without note");
      end else begin
        rd_exp = rd_q.pop_front();
        chk(wb_dat_o, rd_exp, "read data");
      end
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] lo, up, hi, refv, cur, v8;
    logic [31:0] r, v;
    logic rck, msk, expf, ok;
    int src;
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, conv_done} = 5'h0;
    wb_adr_i = 6'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    trg = 3'h0;
    conversion_result = 10'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, reserved and unmapped places
    bus(0, OFS_UPPER, 32'hff);
    bus(0, OFS_LOWER, 32'h00);
    bus(0, OFS_MASK, 32'h01);
    bus(0, OFS_FLAG, 32'h00);
    bus(1, 6'h24, 32'h5a);
    bus(0, 6'h24, 32'h0);
    bus(1, OFS_TRIG, 32'hff);
    bus(0, OFS_TRIG, 32'he3);
    bus(1, OFS_TRIG, 32'h02);
    bus(1, OFS_TRIG, 32'h40);
    bus(0, OFS_TRIG, 32'he3);
    $display("test registers done");
    // Channel codes: legal ones stick, prohibited ones are dropped
    cur = 8'h00;
    for (int c = 0; c < 64; c++) begin
      v8 = {c[5], 2'b00, c[4:0]};
      ok = c[5] ? (c[4:0] <= 1) : (c[4:0] <= 3 || c[4:0] inside {[16:23]});
      if (ok) cur = v8;
      bus(1, OFS_CHAN, {24'h0, v8});
      bus(0, OFS_CHAN, {24'h0, cur});
      chk({26'h0, channel_code}, {26'h0, cur[7], cur[4:0]}, "chan");
    end
    $display("test channels done");
    // Hardware triggers: only the selected source launches
    for (int k = 0; k < 3; k++) begin
      src = (k == 2) ? 3 : k;
      bus(1, OFS_TRIG, (k[0] ? 32'he0 : 32'ha0) | src);
      bus(1, OFS_CTRL, 32'h1);
      chk({31'h0, one_shot}, 32'h1, "one shot");
      pulse((k + 1) % 3);
      pulse((k + 2) % 3);
      wait_start(4, 1'b0, "foreign trigger");
      pulse(k);
      wait_start(4, 1'b1, "selected trigger");
      finish_conv(10'(rnd()));
      bus(0, OFS_FLAG, 32'h1);
    end
    $display("test hardware triggers done");
    // Window compare, flag, mask and interrupt
    bus(1, OFS_TRIG, 32'h20);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      v = rnd();
      lo = r[7:0];
      up = r[15:8];
      hi = (r[17:16] == 0) ? lo : (r[17:16] == 1) ? up : r[25:18];
      rck = r[26];
      msk = i[0];
      refv = {(v[1:0] == 2'h3) ? 2'h2 : v[1:0], v[2], 1'b0, rck, v[3],
              1'b0, v[4]};
      bus(1, OFS_UPPER, {24'h0, up});
      bus(1, OFS_LOWER, {24'h0, lo});
      bus(1, OFS_REF, {24'h0, refv});
      bus(1, OFS_MASK, {31'h0, msk});
      bus(0, OFS_REF, {24'h0, refv});
      chk({27'h0, plus_ref_select, minus_ref_select, snooze_enable,
           resolution_select}, {27'h0, refv[7:5], refv[2], refv[0]},
          "ref outputs");
      bus(1, OFS_CTRL, 32'h3);
      wait_start(6, 1'b1, "software start");
      finish_conv({hi, v[9:8]});
      expf = rck ^ (lo <= hi && hi <= up);
      repeat (3) @(posedge clk);
      chk({31'h0, conversion_end_irq}, {31'h0, expf & ~msk}, "irq");
      bus(0, OFS_STAT, {22'h0, hi, v[9:8]});
      bus(0, OFS_FLAG, {31'h0, expf});
      repeat (2) @(posedge clk);
      chk({31'h0, conversion_end_irq}, 32'h0, "irq after clear");
    end
    bus(1, OFS_REF, 32'hc0);
    bus(0, OFS_REF, {24'h0, refv});
    $display("test window compare done");
    // Sequential mode restarts right after each result
    bus(1, OFS_TRIG, 32'h00);
    bus(1, OFS_CTRL, 32'h3);
    wait_start(6, 1'b1, "sequential start");
    chk({31'h0, one_shot}, 32'h0, "sequential mode");
    finish_conv(10'(rnd()));
    wait_start(1, 1'b1, "sequential restart");
    bus(1, OFS_CTRL, 32'h0);
    $display("test sequential done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule
